// *** mdc_dummy_end.sv ***
// Intentionally empty
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** mdc_host.sv ***
// Host model that streams a bitstream onto the load pins of one device
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Host model
// ****************************************
module mdc_host (
    input  wire logic       hclk,       // Bench clock
    input  wire logic       go,         // Start one frame
    input  wire logic       wide,       // Byte units, else serial bits
    input  wire logic       hi,         // All bytes on high lane
    input  wire logic [7:0] hdr,        // Header unit
    input  wire logic [7:0] n,          // Units in the frame
    output logic            busy,       // Frame running
    output logic            load_clock, // Link clock, 800 ns
    output logic [15:0]     data_in     // Data pins
);
    logic [2:0] div_r;
    logic [7:0] k_r;

    initial begin
        busy = 1'b0;
        load_clock = 1'b0;
        data_in = 16'h5A5A;
        div_r = 3'h0;
        k_r = 8'h00;
    end

    // Unused lanes carry the inverse so a wrong lane choice shows up
    function automatic logic [15:0] unit(input logic [7:0] j);
        logic [7:0] b;
        logic       s;
        b = (j == 8'h00) ? hdr : j;
        s = (j < 8'h08) ? hdr[3'h7 - j[2:0]] : j[0];
        if (!wide) begin
            unit = {{15{~s}}, s};
        end else if (hi) begin
            unit = {b, ~b};
        end else begin
            unit = {~b, b};
        end
    endfunction

    // Clock stands still low outside frames
    always @(posedge hclk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            k_r <= 8'h00;
            div_r <= 3'h0;
            data_in <= unit(8'h00);
        end else if (busy) begin
            div_r <= div_r + 3'h1;
            if (div_r == 3'h3) begin
                load_clock <= 1'b1;
            end
            if (div_r == 3'h7) begin
                load_clock <= 1'b0;
                if (k_r + 8'h01 == n) begin
                    busy <= 1'b0;
                    data_in <= ~data_in;
                end else begin
                    k_r <= k_r + 8'h01;
                    data_in <= unit(k_r + 8'h01);
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** mdc_loader.sv ***
// Configuration loader of one chain device with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1 - Programmer holds chain enable high during flash write
// R2 - Held in reset while reconfigure request low
// R3 - Programmer releases enable and reconfigure when finished
// R4 - Low data byte feeds byte-wide slaves
// R5 - Word-wide: two chains on low, high byte
// R6 - Finished device drives chain enable out low
// R7 - Loading starts one clock after enable
// R8 - User mode only once shared done high
// R9 - Detected error pulls shared error line low
// R10 - Host restarts entire chain after error
// R11 - Enabled identical devices load in lockstep
// R12 - Host sends one serial bit per clock
// R13 - Unused chain enable out usable as gpio
// R14 - Flash wait ignored while loading
// R15 - Cable loading needs manual restart after error
// R16 - Cable mode ignores user startup clock
// R17 - Straps select master and slave schemes
// R18 - Bits sampled on load clock rising edge
module mdc_loader #(
    parameter logic [7:0] SYNC_BYTE = 8'hA5
) (
    input  wire logic        hclk,                    // Bus clock
    input  wire logic        hresetn,                 // Async reset, low
    input  wire logic        ce,                      // Clock enable
    input  wire logic        hsel,                    // Slave select
    input  wire logic [31:0] haddr,                   // Address
    input  wire logic [1:0]  htrans,                  // Transfer type
    input  wire logic        hwrite,                  // Write
    input  wire logic [2:0]  hsize,                   // Size, word only
    input  wire logic [31:0] hwdata,                  // Write data
    input  wire logic        hready,                  // Bus ready
    output logic             hreadyout,               // Slave ready
    output logic             hresp,                   // Always OKAY
    output logic [31:0]      hrdata,                  // Read data
    input  wire logic        load_clock,              // Load clock pin
    input  wire logic [15:0] data_in,                 // Data pins
    input  wire logic        chain_enable_in,         // Enable, low
    input  wire logic        reconfigure_request_low, // Reconfigure, low
    input  wire logic        error_status_low_in,     // Shared error level
    output logic             error_status_low_out,    // Drive value
    output logic             error_status_low_oe,     // Drive enable
    input  wire logic        load_complete_in,        // Shared done level
    output logic             load_complete_out,       // Drive value
    output logic             load_complete_oe,        // Drive enable
    output logic             chain_enable_out,        // Next enable, low
    input  wire logic [3:0]  scheme_select_pins,      // Scheme straps
    input  wire logic        user_startup_clock,      // Startup clock
    input  wire logic        flash_wait,              // Flash wait
    output logic             irq                      // Interrupt level
);
    import mdc_pkg::*;

    mdc_core_t r;
    mdc_core_t n;
    mdc_pins_t pins;
    logic      rise;
    logic      urise;
    logic      serial;
    logic      acc;
    logic      wr;
    logic [7:0]  lane;
    logic [31:0] cnt_n;
    logic [7:0]  hdr_n;

    // ****************************************
    // Register read decode
    // ****************************************
    function automatic logic [31:0] rd_reg(input mdc_core_t c);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (c.ph_a)
            A_CTRL: v[4:0] = c.ctrl;
            A_LEN:  v = c.len;
            A_STAT: v[8:0] = {c.s2.fwait, c.own_err, c.scheme, c.st}; // R14
            A_IRQS: v[2:0] = c.irqs;
            A_IRQM: v[2:0] = c.irqm;
            A_CNT:  v = c.cnt;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    always_comb begin
        pins = '{lclk: load_clock, cein_n: chain_enable_in,
                 rcfg_n: reconfigure_request_low, err_n: error_status_low_in,
                 done: load_complete_in, uclk: user_startup_clock,
                 fwait: flash_wait, sel: scheme_select_pins, data: data_in};
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        n = r;
        // Data settle four clocks before the link edge, so per-bit sync is safe
        n.s1 = pins;
        n.s2 = r.s1;
        n.lclk_p = r.s2.lclk;
        n.uclk_p = r.s2.uclk;
        rise = r.s2.lclk & ~r.lclk_p; // R18
        urise = r.s2.uclk & ~r.uclk_p;
        serial = !((r.scheme == SCH_FPP) || (r.scheme == SCH_AP));
        // Lane choice covers both byte chains of a word-wide load
        lane = r.ctrl[C_HILANE] ? r.s2.data[15:8] : r.s2.data[7:0]; // R4 R5
        cnt_n = r.cnt;
        hdr_n = r.hdr;
        case (r.st)
            ST_RST: begin
                // Strap taken while held, after two flops
                n.scheme = r.s2.sel; // R17
                n.cnt = 32'h0000_0000;
                n.hdr = 8'h00;
                n.own_err = 1'b0;
                n.st = ST_IDLE;
            end
            ST_IDLE: begin
                if (!r.s2.cein_n) begin
                    n.st = ST_LOAD; // R7 R11
                end
            end
            ST_LOAD: begin
                // Flash wait is not looked at here
                if (!r.s2.err_n) begin
                    n.st = ST_ERR; // R9
                end else if (rise) begin
                    if (serial) begin
                        hdr_n = {r.hdr[6:0], r.s2.data[0]};
                        cnt_n = r.cnt + STEP_BIT;
                    end else begin
                        n.byte_r = lane;
                        hdr_n = (r.cnt == 32'h0000_0000) ? lane : r.hdr;
                        cnt_n = r.cnt + STEP_BYTE;
                    end
                    n.cnt = cnt_n;
                    n.hdr = hdr_n;
                    if (cnt_n == HDR_BITS && hdr_n != SYNC_BYTE) begin
                        n.st = ST_ERR; // R9
                        n.own_err = 1'b1;
                    end else if (cnt_n >= r.len) begin
                        n.st = ST_WAIT; // R6
                    end
                end
            end
            ST_WAIT: begin
                if (!r.s2.err_n) begin
                    n.st = ST_ERR;
                end else if (r.s2.done &&
                             (!r.ctrl[C_USRCLK] || r.ctrl[C_CABLE] || urise)) begin
                    n.st = ST_USER; // R8 R16
                end
            end
            ST_USER: n.st = ST_USER;
            // Only a reconfigure request leaves the error state
            ST_ERR:  n.st = ST_ERR;
            default: n.st = ST_RST;
        endcase
        if (!r.s2.rcfg_n) begin
            n.st = ST_RST; // R2
        end

        // Bus data phase
        wr = r.ph_v & r.ph_w & hready;
        if (r.ph_v && !r.ph_w && !r.rd_rdy) begin
            n.rdata = rd_reg(r);
            n.rd_rdy = 1'b1;
        end
        if (wr) begin
            case (r.ph_a)
                A_CTRL: n.ctrl = hwdata[4:0];
                A_LEN:  n.len = hwdata;
                A_IRQM: n.irqm = hwdata[2:0];
                default: n.len = n.len;
            endcase
        end
        if (r.ph_v && hready) begin
            n.ph_v = 1'b0;
        end
        acc = hsel & htrans[1] & hready;
        if (acc) begin
            n.ph_v = 1'b1;
            n.ph_w = hwrite;
            n.ph_a = haddr[7:0];
            n.rd_rdy = 1'b0;
        end

        // Sticky events; a new event wins over the clear
        n.irqs = r.irqs;
        if (wr && r.ph_a == A_IRQS) begin
            n.irqs = r.irqs & ~hwdata[2:0];
        end
        if (n.st == ST_USER && r.st != ST_USER) begin
            n.irqs[I_DONE] = 1'b1;
        end
        if (n.st == ST_ERR && r.st != ST_ERR) begin
            n.irqs[I_ERR] = 1'b1;
        end
        if (n.st == ST_WAIT && r.st != ST_WAIT) begin
            n.irqs[I_HAND] = 1'b1;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.len <= LEN_RST;
            r.ctrl <= CTRL_RST;
            r.irqm <= IRQ_RST;
        end else if (ce) begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // One wait state on reads so read data always leave a flop
    assign hreadyout = ~(r.ph_v & ~r.ph_w & ~r.rd_rdy);
    assign hresp = 1'b0;
    assign hrdata = r.rdata;
    assign irq = |(r.irqs & r.irqm);
    assign error_status_low_out = 1'b0;
    // Held low in reset, and by the device that found the fault
    assign error_status_low_oe = (r.st == ST_RST) | ((r.st == ST_ERR) & r.own_err); // R9
    assign load_complete_out = 1'b0;
    // Released once this device has all its data, so the line is a wired AND
    assign load_complete_oe = ~((r.st == ST_WAIT) | (r.st == ST_USER)); // R8
    always_comb begin
        if (r.st == ST_USER && r.ctrl[C_GPIOEN]) begin
            chain_enable_out = r.ctrl[C_GPIOV]; // R13
        end else begin
            chain_enable_out = ~((r.st == ST_WAIT) | (r.st == ST_USER)); // R6
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_reset_hold: assert property (ce && !r.s2.rcfg_n |=> r.st == ST_RST) // R2
        else $error("not held in reset");
    a_err_reset: assert property (r.st == ST_RST |-> error_status_low_oe) // R2
        else $error("error line not held low in reset");
    a_start_fast: assert property ( // R7
        ce && r.st == ST_IDLE && !r.s2.cein_n && r.s2.rcfg_n |=> r.st == ST_LOAD)
        else $error("load did not start in one cycle");
    a_ceo_done: assert property (r.st == ST_WAIT |-> !chain_enable_out) // R6
        else $error("chain enable out not low after load");
    a_ceo_busy: assert property (r.st == ST_LOAD |-> chain_enable_out) // R6
        else $error("chain enable out low before load end");
    a_user_gate: assert property ( // R8
        r.st == ST_USER && $past(r.st) != ST_USER |-> $past(r.s2.done))
        else $error("user mode without shared done");
    a_done_hold: assert property ( // R8
        r.st == ST_LOAD |-> load_complete_oe && !load_complete_out)
        else $error("done line released before load end");
    a_err_drive: assert property ( // R9
        r.st == ST_ERR && r.own_err |-> error_status_low_oe && !error_status_low_out)
        else $error("own error not driven");
    a_own_err: assert property ( // R9
        r.own_err |-> r.st == ST_ERR || r.st == ST_RST)
        else $error("own error flag outside error state");
    a_err_stop: assert property ( // R9
        ce && r.st == ST_LOAD && !r.s2.err_n && r.s2.rcfg_n |=> r.st == ST_ERR)
        else $error("load not stopped by shared error");
    a_edge_only: assert property ( // R18
        ce && r.st == ST_LOAD && !rise |=> $stable(r.cnt))
        else $error("count moved without load clock rise");
    a_lane_pick: assert property ( // R4
        ce && r.st == ST_LOAD && rise && !serial && !r.ctrl[C_HILANE] && r.s2.err_n
        && r.s2.rcfg_n |=> r.byte_r == $past(r.s2.data[7:0]))
        else $error("wrong low byte lane sampled");
    a_hi_lane: assert property ( // R5
        ce && r.st == ST_LOAD && rise && !serial && r.ctrl[C_HILANE] && r.s2.err_n
        && r.s2.rcfg_n |=> r.byte_r == $past(r.s2.data[15:8]))
        else $error("wrong high byte lane sampled");
    a_wait_ignore: assert property ( // R14
        ce && r.st == ST_LOAD && rise && !serial && r.s2.fwait && r.s2.err_n
        && r.s2.rcfg_n |=> r.cnt == $past(r.cnt) + STEP_BYTE)
        else $error("flash wait held back loading");
    a_cable_start: assert property ( // R16
        ce && r.st == ST_WAIT && r.ctrl[C_CABLE] && r.s2.done && r.s2.err_n
        && r.s2.rcfg_n |=> r.st == ST_USER)
        else $error("cable mode waited for startup clock");
    a_gpio_ceo: assert property ( // R13
        r.st == ST_USER && r.ctrl[C_GPIOEN] |-> chain_enable_out == r.ctrl[C_GPIOV])
        else $error("gpio value not on chain enable out");
    a_irq_done: assert property ( // R8
        ce && r.st != ST_USER ##1 r.st == ST_USER |-> r.irqs[I_DONE])
        else $error("done event not recorded");

    c_user: cover property (r.st == ST_WAIT ##[1:1000] r.st == ST_USER);
    c_err: cover property (r.st == ST_ERR && r.own_err);
    c_irq: cover property ($rose(irq));
    c_cable: cover property (r.st == ST_WAIT && r.ctrl[C_CABLE] ##1 r.st == ST_USER);
    c_hi_lane: cover property (r.st == ST_LOAD && rise && r.ctrl[C_HILANE]);
endmodule
`default_nettype wire

// *** mdc_loader_tb.sv ***
// Self-checking bench for the configuration loader
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module mdc_loader_tb;
    import mdc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, rcfg_n, cein, ext_err, hold_done, uclk;
    logic        fwait, go, wide, hi, hreadyout, hresp, lclk, busy, es_oe, lc_oe, ceo, irq;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  sel;
    logic [7:0]  hdr, n;
    logic [15:0] data;
    int          num_errors, checks_done, cycles;

    // ****************************************
    // Device, host and open-drain lines
    // ****************************************
    mdc_loader i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .load_clock(lclk),
        .data_in(data), .chain_enable_in(cein), .reconfigure_request_low(rcfg_n),
        .error_status_low_in(!(es_oe || ext_err)), .error_status_low_out(),
        .error_status_low_oe(es_oe), .load_complete_in(!(lc_oe || hold_done)),
        .load_complete_out(), .load_complete_oe(lc_oe), .chain_enable_out(ceo),
        .scheme_select_pins(sel), .user_startup_clock(uclk), .flash_wait(fwait), .irq(irq));
    mdc_host i_host (.hclk(hclk), .go(go), .wide(wide), .hi(hi), .hdr(hdr), .n(n),
        .busy(busy), .load_clock(lclk), .data_in(data));

    initial hclk = 1'b0;
    always #50 hclk = ~hclk;

    // ****************************************
    // Bus and sequence tasks
    // ****************************************
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic st(input logic [2:0] e);
        bus(1'b0, A_STAT, 32'h0);
        `CHK("state", e, q[2:0])
    endtask

    task automatic restart(input logic [3:0] s);
        rcfg_n <= 1'b0;
        cein <= 1'b1;
        repeat (8) @(posedge hclk);
        st(3'h0);
        sel <= s;
        rcfg_n <= 1'b1;
        repeat (8) @(posedge hclk);
        st(3'h1);
    endtask

    task automatic arm(input logic [3:0] s, input logic [4:0] c);
        restart(s);
        bus(1'b1, A_CTRL, {27'h0, c});
        bus(1'b1, A_LEN, 32'h0000_0010);
        cein <= 1'b0;
        repeat (4) @(posedge hclk);
        st(3'h2);
    endtask

    task automatic send(input logic [7:0] h, input logic [7:0] c, input logic w, input logic l);
        hdr <= h;
        n <= c;
        wide <= w;
        hi <= l;
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
        while (busy) @(posedge hclk);
        repeat (8) @(posedge hclk);
    endtask

    task automatic final_report;
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A hang costs at most this many cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report;
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {hresetn, hsel, hwrite, rcfg_n, cein, ext_err, hold_done} = 7'b0001100;
        {uclk, fwait, go, wide, hi, htrans, haddr, hwdata} = '0;
        {hsize, sel, hdr, n} = {3'h2, SCH_PS, 8'h00, 8'h01};
        {num_errors, checks_done, cycles} = '0;
        repeat (12) @(posedge hclk);
        `CHK("ceo in reset", 1'b1, ceo)
        `CHK("irq in reset", 1'b0, irq)
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        bus(1'b0, A_LEN, 32'h0);
        `CHK("len reset", LEN_RST, q)
        bus(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, q)
        `CHK("hresp", 1'b0, hresp)
        // Serial load, held in WAIT by another device on the done line
        arm(SCH_PS, 5'h00);
        bus(1'b1, A_IRQM, 32'h0000_0007);
        hold_done <= 1'b1;
        send(8'hA5, 8'h10, 1'b0, 1'b0);
        st(3'h3);
        `CHK("ceo done", 1'b0, ceo)
        `CHK("done drive", 1'b0, lc_oe)
        bus(1'b0, A_CNT, 32'h0);
        `CHK("bit count", 32'h0000_0010, q)
        hold_done <= 1'b0;
        repeat (6) @(posedge hclk);
        st(3'h4);
        bus(1'b0, A_IRQS, 32'h0);
        `CHK("irq status", 32'h0000_0005, q)
        `CHK("irq high", 1'b1, irq)
        bus(1'b1, A_IRQS, 32'h0000_0007);
        @(posedge hclk);
        `CHK("irq clear", 1'b0, irq)
        // Bad header drives the error line
        arm(SCH_PS, 5'h00);
        send(8'h5A, 8'h10, 1'b0, 1'b0);
        st(3'h5);
        `CHK("own error", 1'b1, es_oe)
        // Error seen from another device
        arm(SCH_PS, 5'h00);
        `CHK("error released", 1'b0, es_oe)
        ext_err <= 1'b1;
        repeat (6) @(posedge hclk);
        st(3'h5);
        `CHK("not driving", 1'b0, es_oe)
        ext_err <= 1'b0;
        // Byte loads on the low lane and the high lane
        fwait <= 1'b1;
        hold_done <= 1'b1;
        arm(SCH_FPP, 5'h00);
        send(8'hA5, 8'h02, 1'b1, 1'b0);
        st(3'h3);
        `CHK("wait ignored", 1'b1, q[8])
        `CHK("scheme", SCH_FPP, q[6:3])
        fwait <= 1'b0;
        arm(SCH_AP, 5'h04);
        send(8'hA5, 8'h02, 1'b1, 1'b1);
        st(3'h3);
        // Cable error stays until restarted by hand; then the startup clock is ignored
        hold_done <= 1'b0;
        arm(SCH_PS, 5'h03);
        send(8'h5A, 8'h10, 1'b0, 1'b0);
        repeat (20) @(posedge hclk);
        st(3'h5);
        arm(SCH_PS, 5'h03);
        send(8'hA5, 8'h10, 1'b0, 1'b0);
        st(3'h4);
        bus(1'b1, A_CTRL, 32'h0000_0018);
        @(posedge hclk);
        `CHK("ceo as output", 1'b1, ceo)
        arm(SCH_PS, 5'h01);
        send(8'hA5, 8'h10, 1'b0, 1'b0);
        st(3'h3);
        uclk <= 1'b1;
        repeat (8) @(posedge hclk);
        st(3'h4);
        final_report;
    end
endmodule
`default_nettype wire

// *** mdc_pkg.sv ***
// Constants and types for the multi-device configuration chain loader
`default_nettype none
package mdc_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_LEN  = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_IRQS = 8'h0C;
    localparam logic [7:0] A_IRQM = 8'h10;
    localparam logic [7:0] A_CNT  = 8'h14;
    // Control fields
    localparam int C_USRCLK = 0;
    localparam int C_CABLE  = 1;
    localparam int C_HILANE = 2;
    localparam int C_GPIOEN = 3;
    localparam int C_GPIOV  = 4;
    localparam logic [4:0]  CTRL_RST = 5'h00;
    localparam logic [31:0] LEN_RST  = 32'h0000_1000;
    // Interrupt bits
    localparam int I_DONE = 0;
    localparam int I_ERR  = 1;
    localparam int I_HAND = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // Scheme strap codes
    localparam logic [3:0] SCH_PS  = 4'h0;
    localparam logic [3:0] SCH_FPP = 4'h1;
    localparam logic [3:0] SCH_AP  = 4'h2;
    // Header length in bits, byte and serial step
    localparam logic [31:0] HDR_BITS  = 32'h0000_0008;
    localparam logic [31:0] STEP_BIT  = 32'h0000_0001;
    localparam logic [31:0] STEP_BYTE = 32'h0000_0008;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_RST  = 3'b000,
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_WAIT = 3'b011,
        ST_USER = 3'b100,
        ST_ERR  = 3'b101
    } mdc_state_t;
    typedef struct packed {
        logic        lclk;
        logic        cein_n;
        logic        rcfg_n;
        logic        err_n;
        logic        done;
        logic        uclk;
        logic        fwait;
        logic [3:0]  sel;
        logic [15:0] data;
    } mdc_pins_t;
    typedef struct packed {
        mdc_pins_t   s1;
        mdc_pins_t   s2;
        logic        lclk_p;
        logic        uclk_p;
        mdc_state_t  st;
        logic [3:0]  scheme;
        logic        own_err;
        logic [31:0] cnt;
        logic [7:0]  hdr;
        logic [7:0]  byte_r;
        logic [4:0]  ctrl;
        logic [31:0] len;
        logic [2:0]  irqs;
        logic [2:0]  irqm;
        logic        ph_v;
        logic        ph_w;
        logic        rd_rdy;
        logic [7:0]  ph_a;
        logic [31:0] rdata;
    } mdc_core_t;
endpackage
`default_nettype wire
